// ==== rtl/ddt_pkg.sv ====
/*
 * ddt_pkg: constants for the device-related diagnostic telegram builder
 * (telegram bytes 9 to 28). Assumes nothing of its surroundings.
 */
package ddt_pkg;
	localparam int DDT_FIRST_BYTE = 9;
	localparam int DDT_LAST_BYTE = 28;
	localparam int DDT_NUM_BYTES = 20;
	localparam logic [4:0] DDT_IDX_W_LAST = 5'h13;
	// fixed bytes
	localparam logic [7:0] DDT_LEN_VAL = 8'h14;
	localparam logic [7:0] DDT_ALARM_DIAG = 8'h01;
	localparam logic [7:0] DDT_SLOT_SAFETY = 8'h03;
	localparam logic [7:0] DDT_SLOT_GATEWAY = 8'h04;
	localparam logic [7:0] DDT_FILL_14 = 8'h1c;
	localparam logic [7:0] DDT_FILL_17 = 8'h7f;
	localparam logic [7:0] DDT_FILL_18 = 8'h40;
	localparam logic [7:0] DDT_FILL_19 = 8'h01;
	localparam logic [7:0] DDT_FILL_20 = 8'h01;
	// specifier codes, byte 12 bits 1:0
	localparam logic [1:0] DDT_SPEC_NONE = 2'h0;
	localparam logic [1:0] DDT_SPEC_IN = 2'h1;
	localparam logic [1:0] DDT_SPEC_OUT_OK = 2'h2;
	localparam logic [1:0] DDT_SPEC_OUT_BAD = 2'h3;
	// module status 1 (byte 13) bit positions
	localparam int DDT_MS1_GROUP = 0;
	localparam int DDT_MS1_INT = 1;
	localparam int DDT_MS1_EXT = 2;
	localparam int DDT_MS1_CFG = 3;
	localparam int DDT_MS1_UV = 4;
	// module status 2 (byte 15)
	localparam int DDT_MS2_CFG = 0;
	localparam int DDT_MS2_OFFL = 2;
	localparam int DDT_MS2_WDOG = 3;
	// module status 3 (byte 16)
	localparam int DDT_MS3_NVM = 2;
	// byte positions within the 20 byte image
	localparam int DDT_B_LEN = 0;
	localparam int DDT_B_ALARM = 1;
	localparam int DDT_B_SLOT = 2;
	localparam int DDT_B_SPEC = 3;
	localparam int DDT_B_MS1 = 4;
	localparam int DDT_B_F14 = 5;
	localparam int DDT_B_MS2 = 6;
	localparam int DDT_B_MS3 = 7;
	localparam int DDT_B_F17 = 8;
	localparam int DDT_B_F18 = 9;
	localparam int DDT_B_F19 = 10;
	localparam int DDT_B_F20 = 11;
	localparam int DDT_B_SLV_A = 12;
	localparam int DDT_B_SLV_B = 16;
	typedef enum logic {DDT_SRC_SAFETY, DDT_SRC_GATEWAY} ddt_src_e;
endpackage

// ==== rtl/ddt_slave_map.sv ====
/*
 * ddt_slave_map: per-slave fault bits from the target and actual lists.
 * Assumes the lists are synchronous to core_clk; registers its output.
 */
`timescale 1ns/1ps
module ddt_slave_map (
	// clock and reset
	input wire logic core_clk,
	input wire logic resetn,
	// slave lists, bit n is address n
	input wire logic [31:0] cfg_a,
	input wire logic [31:0] cfg_b,
	input wire logic [31:0] act_a,
	input wire logic [31:0] act_b,
	// fault bits, bit n is address n
	output logic [31:0] flt_a,
	output logic [31:0] flt_b
);
	import ddt_pkg::*;
	logic [31:0] flt_a_reg, flt_a_next, flt_b_reg, flt_b_next;

	function automatic logic [31:0] mismatch(input logic [31:0] c, input logic [31:0] a);
		return c ^ a;
	endfunction

	always_comb begin
		flt_a_next = mismatch(cfg_a, act_a);
		flt_b_next = mismatch(cfg_b, act_b);
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			flt_a_reg <= 32'h0;
			flt_b_reg <= 32'h0;
		end else begin
			flt_a_reg <= flt_a_next;
			flt_b_reg <= flt_b_next;
		end
	end

	assign flt_a = flt_a_reg;
	assign flt_b = flt_b_reg;

	a_slave_fault: assert property (@(posedge core_clk) disable iff (!resetn)
		1'b1 |=> flt_a == ($past(cfg_a) ^ $past(act_a)))
		else $error("slave fault bits wrong");
endmodule

// ==== rtl/ddt_builder.sv ====
/*
 * ddt_builder: builds telegram bytes 9..28 of the device diagnosis.
 * Fault inputs are levels from logic on core_clk; the master reads
 * any byte through rd_idx (0 = byte 9) with one cycle of latency.
 */
// Function
// - length 14h at byte 9; fillers 1Ch, 7Fh, 40h, 01h, 01h at 14,17..20.
// - byte 10 is 01h; byte 11 is 03h safety slot or 04h gateway slot.
// - byte 12 bits 1:0 carry none, incoming, outgoing ok, outgoing still bad.
// - byte 13 bit 0 group fault, bit 2 external fault.
// - byte 13 bit 1 internal fault or memory defect; byte 16 bit 2 memory defect only.
// - target mismatch sets byte 13 bit 3 and byte 15 bit 0.
// - byte 13 bit 4 on low supply; bits 7:5 zero.
// - byte 15 bit 2 is offline state; bits 1 and 7:4 zero.
// - byte 15 bit 3 on watchdog hardware fault.
// - slave fault bit when configured slave missing or unconfigured slave present.
// - slaves 0..31 and A into bytes 21..24, lowest address in bit 0.
// - B slaves 0B..31B into bytes 25..28, lowest address in bit 0.
// - each error bit is one when present, zero when absent.
`timescale 1ns/1ps
module ddt_builder (
	// clock and reset
	input wire logic core_clk,
	input wire logic resetn,
	// fault inputs
	input wire logic internal_fault,
	input wire logic nvm_defect,
	input wire logic segment_power_fail,
	input wire logic offline,
	input wire logic watchdog_fault,
	input wire logic safety_fault,
	// slave lists
	input wire logic [31:0] cfg_a,
	input wire logic [31:0] cfg_b,
	input wire logic [31:0] act_a,
	input wire logic [31:0] act_b,
	// read port
	input wire logic [4:0] rd_idx,
	output logic [7:0] rd_data,
	// interrupt event toward the master
	output logic alarm_pulse
);
	import ddt_pkg::*;
	logic [31:0] flt_a, flt_b;
	logic gw_flt, gw_flt_reg, gw_flt_next, sf_flt_reg, sf_flt_next;
	logic [1:0] spec_reg, spec_next;
	ddt_src_e src_reg, src_next;
	logic alarm_reg, alarm_next;
	logic [7:0] tel_reg [DDT_NUM_BYTES];
	logic [7:0] tel_next [DDT_NUM_BYTES];
	logic [7:0] rd_reg, rd_next;
	logic ext_f, cfg_f, slv_any;
	logic slv_img_any;

	ddt_slave_map ddt_slave_map_i (
		.core_clk(core_clk),
		.resetn(resetn),
		.cfg_a(cfg_a),
		.cfg_b(cfg_b),
		.act_a(act_a),
		.act_b(act_b),
		.flt_a(flt_a),
		.flt_b(flt_b)
	);

	function automatic logic [1:0] out_spec(input logic other_bad);
		return other_bad ? DDT_SPEC_OUT_BAD : DDT_SPEC_OUT_OK;
	endfunction

	// ------------------------------------------------------------
	// image assembly
	// ------------------------------------------------------------
	always_comb begin
		slv_any = |{flt_a, flt_b};
		cfg_f = slv_any;
		ext_f = slv_any | segment_power_fail;
		gw_flt = ext_f | internal_fault | nvm_defect | offline | watchdog_fault;
		tel_next[DDT_B_LEN] = DDT_LEN_VAL;
		tel_next[DDT_B_F14] = DDT_FILL_14;
		tel_next[DDT_B_F17] = DDT_FILL_17;
		tel_next[DDT_B_F18] = DDT_FILL_18;
		tel_next[DDT_B_F19] = DDT_FILL_19;
		tel_next[DDT_B_F20] = DDT_FILL_20;
		tel_next[DDT_B_ALARM] = DDT_ALARM_DIAG;
		tel_next[DDT_B_SLOT] = (src_reg == DDT_SRC_SAFETY) ? DDT_SLOT_SAFETY : DDT_SLOT_GATEWAY;
		tel_next[DDT_B_SPEC] = {6'h0, spec_reg};
		tel_next[DDT_B_MS1] = 8'h0;
		tel_next[DDT_B_MS1][DDT_MS1_EXT] = ext_f;
		tel_next[DDT_B_MS1][DDT_MS1_INT] = internal_fault | nvm_defect;
		tel_next[DDT_B_MS1][DDT_MS1_CFG] = cfg_f;
		tel_next[DDT_B_MS1][DDT_MS1_UV] = segment_power_fail;
		tel_next[DDT_B_MS1][DDT_MS1_GROUP] = gw_flt;
		tel_next[DDT_B_MS2] = 8'h0;
		tel_next[DDT_B_MS2][DDT_MS2_CFG] = cfg_f;
		tel_next[DDT_B_MS2][DDT_MS2_OFFL] = offline;
		tel_next[DDT_B_MS2][DDT_MS2_WDOG] = watchdog_fault;
		tel_next[DDT_B_MS3] = 8'h0;
		tel_next[DDT_B_MS3][DDT_MS3_NVM] = nvm_defect;
		for (int i = 0; i < 4; i++) begin
			tel_next[DDT_B_SLV_A + i] = flt_a[i*8 +: 8];
			tel_next[DDT_B_SLV_B + i] = flt_b[i*8 +: 8];
		end
	end

	// ------------------------------------------------------------
	// interrupt tracking
	// ------------------------------------------------------------
	// change of slot fault state
	always_comb begin
		gw_flt_next = gw_flt;
		sf_flt_next = safety_fault;
		spec_next = spec_reg;
		src_next = src_reg;
		alarm_next = 1'b0;
		if (gw_flt != gw_flt_reg) begin
			alarm_next = 1'b1;
			src_next = DDT_SRC_GATEWAY;
			spec_next = gw_flt ? DDT_SPEC_IN : out_spec(1'b0);
		end else if (safety_fault != sf_flt_reg) begin
			alarm_next = 1'b1;
			src_next = DDT_SRC_SAFETY;
			spec_next = safety_fault ? DDT_SPEC_IN : out_spec(gw_flt);
		end
	end

	always_comb begin
		rd_next = (rd_idx <= DDT_IDX_W_LAST) ? tel_reg[rd_idx] : 8'h0;
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			gw_flt_reg <= 1'b0;
			sf_flt_reg <= 1'b0;
			spec_reg <= DDT_SPEC_NONE;
			src_reg <= DDT_SRC_GATEWAY;
			alarm_reg <= 1'b0;
			rd_reg <= 8'h0;
			for (int i = 0; i < DDT_NUM_BYTES; i++) begin
				tel_reg[i] <= 8'h0;
			end
		end else begin
			gw_flt_reg <= gw_flt_next;
			sf_flt_reg <= sf_flt_next;
			spec_reg <= spec_next;
			src_reg <= src_next;
			alarm_reg <= alarm_next;
			rd_reg <= rd_next;
			for (int i = 0; i < DDT_NUM_BYTES; i++) begin
				tel_reg[i] <= tel_next[i];
			end
		end
	end

	assign rd_data = rd_reg;
	assign alarm_pulse = alarm_reg;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	// any slave fault bit in the image, for the checks below
	always_comb begin
		slv_img_any = 1'b0;
		for (int i = 0; i < 8; i++) begin
			slv_img_any = slv_img_any | (|tel_reg[DDT_B_SLV_A + i]);
		end
	end

	a_length_byte: assert property (@(posedge core_clk) disable iff (!resetn)
		$past(resetn) && rd_idx == 5'h0 |=> rd_data == DDT_LEN_VAL)
		else $error("length byte wrong");
	a_slot_code: assert property (@(posedge core_clk) disable iff (!resetn)
		$past(resetn) |-> (tel_reg[DDT_B_SLOT] == DDT_SLOT_SAFETY || tel_reg[DDT_B_SLOT] == DDT_SLOT_GATEWAY)
		&& ((tel_reg[DDT_B_SLOT] == DDT_SLOT_SAFETY) == ($past(src_reg) == DDT_SRC_SAFETY)))
		else $error("slot code illegal");
	a_spec_incoming: assert property (@(posedge core_clk) disable iff (!resetn)
		$rose(gw_flt_reg) |-> spec_reg == DDT_SPEC_IN && src_reg == DDT_SRC_GATEWAY)
		else $error("incoming specifier wrong");
	a_spec_outgoing: assert property (@(posedge core_clk) disable iff (!resetn)
		$past(resetn) && $fell(gw_flt_reg) |-> spec_reg == DDT_SPEC_OUT_OK && src_reg == DDT_SRC_GATEWAY)
		else $error("outgoing specifier wrong");
	a_ext_fault: assert property (@(posedge core_clk) disable iff (!resetn)
		segment_power_fail |=> tel_reg[DDT_B_MS1][DDT_MS1_EXT] && tel_reg[DDT_B_MS1][DDT_MS1_UV])
		else $error("external fault not shown");
	a_nvm_byte: assert property (@(posedge core_clk) disable iff (!resetn)
		nvm_defect |=> tel_reg[DDT_B_MS3] == 8'h04)
		else $error("memory defect byte wrong");
	a_mismatch_pair: assert property (@(posedge core_clk) disable iff (!resetn)
		tel_reg[DDT_B_MS1][DDT_MS1_CFG] == tel_reg[DDT_B_MS2][DDT_MS2_CFG]
		&& tel_reg[DDT_B_MS1][DDT_MS1_CFG] == slv_img_any)
		else $error("mismatch bits differ");
	a_ms1_reserved: assert property (@(posedge core_clk) disable iff (!resetn)
		tel_reg[DDT_B_MS1][7:5] == 3'h0)
		else $error("reserved bits set");
	a_offline_bit: assert property (@(posedge core_clk) disable iff (!resetn)
		$past(resetn) |-> tel_reg[DDT_B_MS2][DDT_MS2_OFFL] == $past(offline)
		&& tel_reg[DDT_B_MS2][7:4] == 4'h0 && !tel_reg[DDT_B_MS2][1])
		else $error("offline bit wrong");
	a_watchdog_bit: assert property (@(posedge core_clk) disable iff (!resetn)
		$past(resetn) |-> tel_reg[DDT_B_MS2][DDT_MS2_WDOG] == $past(watchdog_fault))
		else $error("watchdog bit wrong");
	a_slave_a_bytes: assert property (@(posedge core_clk) disable iff (!resetn)
		$past(resetn) && $past(resetn, 2) |-> {tel_reg[DDT_B_SLV_A + 3], tel_reg[DDT_B_SLV_A + 2],
		tel_reg[DDT_B_SLV_A + 1], tel_reg[DDT_B_SLV_A]} == ($past(cfg_a, 2) ^ $past(act_a, 2)))
		else $error("slave A bytes wrong");
	a_slave_b_bytes: assert property (@(posedge core_clk) disable iff (!resetn)
		$past(resetn) && $past(resetn, 2) |-> {tel_reg[DDT_B_SLV_B + 3], tel_reg[DDT_B_SLV_B + 2],
		tel_reg[DDT_B_SLV_B + 1], tel_reg[DDT_B_SLV_B]} == ($past(cfg_b, 2) ^ $past(act_b, 2)))
		else $error("slave B bytes wrong");
	a_group_bit: assert property (@(posedge core_clk) disable iff (!resetn)
		tel_reg[DDT_B_MS1][DDT_MS1_GROUP] == ((|tel_reg[DDT_B_MS1][7:1]) || (|tel_reg[DDT_B_MS2])
		|| (|tel_reg[DDT_B_MS3]) || slv_img_any))
		else $error("group bit wrong");
	a_alarm_edge: assert property (@(posedge core_clk) disable iff (!resetn)
		gw_flt != gw_flt_reg |=> alarm_pulse)
		else $error("alarm not raised");
	a_safety_alarm: assert property (@(posedge core_clk) disable iff (!resetn)
		safety_fault != sf_flt_reg && gw_flt == gw_flt_reg |=> alarm_pulse && src_reg == DDT_SRC_SAFETY)
		else $error("safety alarm wrong");
	c_gw_alarm: cover property (@(posedge core_clk) disable iff (!resetn) $rose(gw_flt_reg));
	c_out_bad: cover property (@(posedge core_clk) disable iff (!resetn) spec_reg == DDT_SPEC_OUT_BAD);
	c_safety: cover property (@(posedge core_clk) disable iff (!resetn) src_reg == DDT_SRC_SAFETY);
	c_slave_fault: cover property (@(posedge core_clk) disable iff (!resetn) slv_img_any);
endmodule

// ==== dv/ddt_dp_master.sv ====
/*
 * ddt_dp_master: master-side reader of the diagnostic telegram bytes.
 * Assumes the builder answers a byte select one core_clk cycle later.
 */
`timescale 1ns/1ps
module ddt_dp_master (
	// clock
	input wire logic core_clk,
	// read port
	output logic [4:0] rd_idx,
	input wire logic [7:0] rd_data
);
	initial rd_idx = 5'h00;
	// select after an edge, take the registered answer two edges on
	task automatic read_byte(input logic [4:0] idx, output logic [7:0] d);
		@(posedge core_clk);
		rd_idx <= idx;
		@(posedge core_clk);
		@(posedge core_clk);
		d = rd_data;
	endtask
endmodule

// ==== dv/ddt_builder_tb.sv ====
/*
 * ddt_builder_tb: self-checking bench of the diagnostic telegram builder.
 * Assumes ddt_pkg, the builder and the master model are compiled first.
 */
`timescale 1ns/1ps
module ddt_builder_tb;
	import ddt_pkg::*;
	logic core_clk = 1'b0;
	logic resetn = 1'b0;
	// gateway flags: internal, memory, power, offline, watchdog
	logic [4:0] gw = 5'h00;
	logic saf = 1'b0;
	logic [31:0] cfg_a = 32'h0, cfg_b = 32'h0, act_a = 32'h0, act_b = 32'h0;
	logic [4:0] rd_idx;
	logic [7:0] rd_data;
	logic alarm_pulse;
	int fail_count = 0;
	int n_checks = 0;
	int n_alarm = 0;
	int a0;
	logic [63:0] sb;
	// expected status bytes 13, 15, 16 per gateway flag
	logic [23:0] ms_tab [5] = '{24'h03_00_00, 24'h03_00_04, 24'h15_00_00, 24'h01_04_00, 24'h01_08_00};

	always #2 core_clk = ~core_clk;
	always @(posedge core_clk) if (alarm_pulse === 1'b1) n_alarm <= n_alarm + 1;

	ddt_builder ddt_builder_i (.core_clk(core_clk), .resetn(resetn), .internal_fault(gw[4]), .nvm_defect(gw[3]),
		.segment_power_fail(gw[2]), .offline(gw[1]), .watchdog_fault(gw[0]), .safety_fault(saf), .cfg_a(cfg_a),
		.cfg_b(cfg_b), .act_a(act_a), .act_b(act_b), .rd_idx(rd_idx), .rd_data(rd_data), .alarm_pulse(alarm_pulse));
	ddt_dp_master ddt_dp_master_i (.core_clk(core_clk), .rd_idx(rd_idx), .rd_data(rd_data));

	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			$display("mismatch %s expected %h seen %h", what, exp, seen);
			fail_count++;
		end
	endtask

	task automatic rd(input logic [4:0] idx, input logic [7:0] exp);
		logic [7:0] d;
		ddt_dp_master_i.read_byte(idx, d);
		check($sformatf("byte %0d", idx + 9), d, exp);
	endtask

	// apply slot faults, let the image settle, compare the alarms raised
	task automatic step(input logic [4:0] g, input logic s, input logic [7:0] n_exp);
		@(posedge core_clk);
		a0 = n_alarm;
		gw <= g;
		saf <= s;
		repeat (6) @(posedge core_clk);
		check("alarm count", 8'(n_alarm - a0), n_exp);
	endtask

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	initial begin
		#20000;
		fail_count++;
		end_of_test();
	end

	initial begin
		repeat (10) @(posedge core_clk);
		resetn <= 1'b1;
		repeat (3) @(posedge core_clk);
		for (int i = 0; i < 32; i++)
			rd(5'(i), (i == 0) ? 8'h14 : (i == 1 || i == 10 || i == 11) ? 8'h01 : (i == 2) ? 8'h04 :
				(i == 5) ? 8'h1c : (i == 8) ? 8'h7f : (i == 9) ? 8'h40 : 8'h00);
		check("idle alarm count", 8'(n_alarm), 8'h00);
		$display("test fixed bytes done");
		// gateway faults one at a time
		for (int k = 0; k < 5; k++) begin
			step(5'h10 >> k, 1'b0, 8'h01);
			rd(5'h02, 8'h04);
			rd(5'h03, 8'h01);
			rd(5'h04, ms_tab[k][23:16]);
			rd(5'h06, ms_tab[k][15:8]);
			rd(5'h07, ms_tab[k][7:0]);
			step(5'h00, 1'b0, 8'h01);
			rd(5'h03, 8'h02);
			rd(5'h04, 8'h00);
		end
		$display("test module status done");
		// safety slot, outgoing while gateway still faulty
		step(5'h10, 1'b0, 8'h01);
		step(5'h10, 1'b1, 8'h01);
		rd(5'h02, 8'h03);
		rd(5'h03, 8'h01);
		rd(5'h04, 8'h03);
		step(5'h10, 1'b0, 8'h01);
		rd(5'h03, 8'h03);
		step(5'h00, 1'b0, 8'h01);
		rd(5'h02, 8'h04);
		step(5'h00, 1'b1, 8'h01);
		step(5'h00, 1'b0, 8'h01);
		rd(5'h02, 8'h03);
		rd(5'h03, 8'h02);
		$display("test slots done");
		// missing, unconfigured and matched slaves at byte edges
		@(posedge core_clk);
		a0 = n_alarm;
		cfg_a <= 32'h0000_0003;
		act_a <= 32'h0100_0002;
		cfg_b <= 32'h8000_0000;
		act_b <= 32'h0000_0100;
		repeat (6) @(posedge core_clk);
		sb = 64'h80_00_01_00_01_00_00_01;
		for (int j = 0; j < 8; j++)
			rd(5'(12 + j), sb[8*j +: 8]);
		rd(5'h04, 8'h0d);
		rd(5'h06, 8'h01);
		rd(5'h03, 8'h01);
		check("alarm count", 8'(n_alarm - a0), 8'h01);
		$display("test slave map done");
		// reset with slave faults present, incoming alarm after release
		@(posedge core_clk);
		resetn <= 1'b0;
		repeat (2) @(posedge core_clk);
		a0 = n_alarm;
		resetn <= 1'b1;
		repeat (6) @(posedge core_clk);
		check("alarm count", 8'(n_alarm - a0), 8'h01);
		rd(5'h03, 8'h01);
		rd(5'h0c, 8'h01);
		rd(5'h04, 8'h0d);
		$display("test reset done");
		end_of_test();
	end
endmodule
